// ==== shared/seq_pkg.sv ====
// shared constants and carrier types for the converter sequencer
package seq_pkg;

    // ****************************************
    // target addressing
    // ****************************************
    localparam logic [6:0] ADDR_STRAP_LOW  = 7'h75;
    localparam logic [6:0] ADDR_STRAP_HIGH = 7'h74;

    // ****************************************
    // register offsets and field positions
    // ****************************************
    localparam logic [7:0] REG_REF_LSB  = 8'h00;
    localparam logic [7:0] REG_REF_MSB  = 8'h01;
    localparam logic [7:0] REG_MODE_CTL = 8'h06;
    localparam int         OE_POS       = 7;
    localparam int         OUTPUT_DISCHARGE_BIT_POS   = 4;
    localparam int         HICCUP_POS   = 5;
    localparam int         FPWM_POS     = 1;
    localparam int         REF_W        = 11;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] REF_LSB_RST  = 8'h00;
    localparam logic [7:0] REF_MSB_RST  = 8'h00;
    localparam logic [7:0] MODE_CTL_RST = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int SOFT_START_US   = 3600;
    localparam int HICCUP_OFF_MS   = 76;
    localparam int SOFT_START_CYC  = SOFT_START_US * (CLK_HZ / 1_000_000);
    localparam int HICCUP_OFF_CYC  = HICCUP_OFF_MS * (CLK_HZ / 1000);

    // ****************************************
    // enumerations and carriers
    // ****************************************
    typedef enum logic [3:0] {
        ST_OFF     = 4'b0001,
        ST_STANDBY = 4'b0010,
        ST_ACTIVE  = 4'b0100,
        ST_HICCUP  = 4'b1000
    } seq_state_t;

    typedef enum logic [1:0] {
        STAGE_IDLE  = 2'h0,
        STAGE_BUCK  = 2'h1,
        STAGE_BOOST = 2'h2,
        STAGE_ALT   = 2'h3
    } stage_mode_t;

    typedef struct packed {
        logic input_undervoltage_lockout;
        logic input_above_upper;
        logic enable_standby;
        logic enable_active;
        logic enable_shutdown;
        logic vin_gt_vout;
        logic vin_lt_vout;
        logic vin_above_bias_hi;
        logic vin_below_bias_lo;
        logic vout_above_bias_hi;
        logic vout_below_bias_lo;
        logic output_short;
        logic output_overvoltage_guard;
        logic discharge_done;
        logic light_load;
        logic external_bias_select;
        logic addr_strap;
    } sense_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic [7:0] reg_addr;
        logic [7:0] data;
    } reg_write_t;

endpackage

// ==== hdl/buck_boost_control_sequencer.sv ====
// enable, soft-start, mode and protection sequencing for the buck-boost converter
// Operation
// (R1) target address 75h when strap low, 74h when strap high
// (R2) standby with qualified input: sample strap and latch address
// (R3) enable above threshold with qualified input permits i2c and switching
// (R4) stay disabled in undervoltage; enable only above upper limit and enable high
// (R5) controller writes configuration before setting output enable
// (R6) output enable rising ramps reference from zero to target over 3.6 ms
// (R7) reference target is 11-bit code from the two reference registers
// (R8) buck if vin above vout, boost if below, alternate when close
// (R9) light load: pfm automatically or forced pwm by a register bit
// (R10) hiccup on short: stop 76 ms, then fresh soft-start
// (R11) overvoltage switches off both high-side transistors
// (R12) bias source chosen from vin/vout against 6.2/5.9 V thresholds
// (R13) external bias when select pin low, internal regulator when high
// (R14) enable below shutdown level disables all and resets registers
// (R15) output enable cleared halts switching, i2c stays active
// (R16) output enable cleared with discharge bit sinks current until low
// (R17) analog comparator results synchronized by two flops before use
// (R18) writes to latched address update the register on acknowledge
`timescale 1ns/1ns
module buck_boost_control_sequencer #(
    parameter int SOFT_START_CYCLES = seq_pkg::SOFT_START_CYC,
    parameter int HICCUP_CYCLES     = seq_pkg::HICCUP_OFF_CYC
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 reset_in,
    // comparator inputs, asynchronous
    input  wire seq_pkg::sense_t      sense_in,
    // register writes from the i2c target front end
    input  wire seq_pkg::reg_write_t  reg_write_in,
    // status and control outputs
    output logic [6:0]                target_addr_out,
    output logic                      i2c_enable_out,
    output logic                      switching_out,
    output logic [10:0]               reference_out,
    output logic [1:0]                stage_mode_out,
    output logic                      pfm_out,
    output logic                      high_side_off_out,
    output logic                      discharge_out,
    output logic                      bias_from_vin_out,
    output logic                      bias_external_out,
    output logic [3:0]                state_out
);

    // the ramp needs at least one cycle per reference code
    if (SOFT_START_CYCLES < 2048 || HICCUP_CYCLES < 1) begin : g_bad_cycles
        $error("cycle counts too small for ramp");
    end

    // ****************************************
    // synchronisers
    // ****************************************
    seq_pkg::sense_t meta_q;
    seq_pkg::sense_t sync_q;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= sense_in; // R17
            sync_q <= meta_q;   // R17
        end
    end

    wire logic shutdown_w = sync_q.enable_shutdown;
    wire logic input_ok_w = !sync_q.input_undervoltage_lockout && sync_q.input_above_upper;

    // ****************************************
    // sequencing state
    // ****************************************
    seq_pkg::seq_state_t state_q;
    logic [31:0]         hiccup_cnt_q;
    logic                ramp_start;
    logic [7:0]          ref_lsb_q;
    logic [7:0]          ref_msb_q;
    logic [7:0]          mode_ctl_q;
    wire logic           oe_w     = mode_ctl_q[seq_pkg::OE_POS];
    wire logic           hiccup_w = mode_ctl_q[seq_pkg::HICCUP_POS];

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q      <= seq_pkg::ST_OFF;
            hiccup_cnt_q <= '0;
        end else if (shutdown_w || !input_ok_w) begin
            state_q      <= seq_pkg::ST_OFF; // R4 R14
            hiccup_cnt_q <= '0;
        end else begin
            case (state_q)
                seq_pkg::ST_OFF: begin
                    if (sync_q.enable_standby || sync_q.enable_active) begin
                        state_q <= seq_pkg::ST_STANDBY; // R2
                    end
                end
                seq_pkg::ST_STANDBY: begin
                    if (sync_q.enable_active) begin
                        state_q <= seq_pkg::ST_ACTIVE; // R3
                    end
                end
                seq_pkg::ST_ACTIVE: begin
                    if (!sync_q.enable_active) begin
                        state_q <= seq_pkg::ST_STANDBY;
                    end else if (hiccup_w && oe_w && sync_q.output_short) begin
                        state_q      <= seq_pkg::ST_HICCUP; // R10
                        hiccup_cnt_q <= '0;
                    end
                end
                seq_pkg::ST_HICCUP: begin
                    if (hiccup_cnt_q == 32'(HICCUP_CYCLES - 1)) begin
                        state_q <= seq_pkg::ST_ACTIVE; // R10
                    end else begin
                        hiccup_cnt_q <= hiccup_cnt_q + 32'h1;
                    end
                end
                default: state_q <= seq_pkg::ST_OFF;
            endcase
        end
    end

    // ****************************************
    // address latch
    // ****************************************
    logic [6:0] addr_q;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            addr_q <= seq_pkg::ADDR_STRAP_LOW;
        end else if (shutdown_w) begin
            addr_q <= seq_pkg::ADDR_STRAP_LOW; // R14
        end else if (state_q == seq_pkg::ST_OFF && !shutdown_w && input_ok_w
                     && (sync_q.enable_standby || sync_q.enable_active)) begin
            // R1 R2
            addr_q <= sync_q.addr_strap ? seq_pkg::ADDR_STRAP_HIGH : seq_pkg::ADDR_STRAP_LOW;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // writes accepted only while i2c is live; configuration may precede oe
    wire logic i2c_live_w = (state_q == seq_pkg::ST_ACTIVE) || (state_q == seq_pkg::ST_HICCUP);
    wire logic wr_w = reg_write_in.valid && i2c_live_w && reg_write_in.addr == addr_q; // R18 R5
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ref_lsb_q  <= seq_pkg::REF_LSB_RST;
            ref_msb_q  <= seq_pkg::REF_MSB_RST;
            mode_ctl_q <= seq_pkg::MODE_CTL_RST;
        end else if (shutdown_w) begin
            ref_lsb_q  <= seq_pkg::REF_LSB_RST; // R14
            ref_msb_q  <= seq_pkg::REF_MSB_RST;
            mode_ctl_q <= seq_pkg::MODE_CTL_RST;
        end else if (wr_w) begin
            case (reg_write_in.reg_addr)
                seq_pkg::REG_REF_LSB:  ref_lsb_q  <= reg_write_in.data; // R18
                seq_pkg::REG_REF_MSB:  ref_msb_q  <= reg_write_in.data;
                seq_pkg::REG_MODE_CTL: mode_ctl_q <= reg_write_in.data;
                default:               ;
            endcase
        end
    end

    // ****************************************
    // soft-start ramp
    // ****************************************
    // low byte holds ref[7:0], msb register low three bits hold ref[10:8]
    wire logic [10:0] target_w = {ref_msb_q[2:0], ref_lsb_q}; // R7
    wire logic        run_w    = (state_q == seq_pkg::ST_ACTIVE) && oe_w;
    logic             run_prev_q;
    logic [10:0]      ref_q;
    logic [31:0]      step_cnt_q;
    // one code step every ss/2048 cycles, so full scale takes the soft-start time
    localparam int STEP_CYC = SOFT_START_CYCLES / 2048;

    assign ramp_start = run_w && !run_prev_q;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            run_prev_q <= 1'b0;
            ref_q      <= '0;
            step_cnt_q <= '0;
        end else begin
            run_prev_q <= run_w;
            if (!run_w || ramp_start) begin
                ref_q      <= '0; // R6 R10
                step_cnt_q <= '0;
            end else if (ref_q > target_w) begin
                ref_q <= target_w;
            end else if (ref_q != target_w) begin
                if (step_cnt_q == 32'(STEP_CYC - 1)) begin
                    step_cnt_q <= '0;
                    ref_q      <= ref_q + 11'h1; // R6
                end else begin
                    step_cnt_q <= step_cnt_q + 32'h1;
                end
            end
        end
    end

    // ****************************************
    // output registers
    // ****************************************
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            target_addr_out   <= seq_pkg::ADDR_STRAP_LOW;
            i2c_enable_out    <= 1'b0;
            switching_out     <= 1'b0;
            reference_out     <= '0;
            stage_mode_out    <= seq_pkg::STAGE_IDLE;
            pfm_out           <= 1'b0;
            high_side_off_out <= 1'b1;
            discharge_out     <= 1'b0;
            bias_from_vin_out <= 1'b1;
            bias_external_out <= 1'b0;
            state_out         <= seq_pkg::ST_OFF;
        end else begin
            target_addr_out <= addr_q;
            i2c_enable_out  <= i2c_live_w;          // R3 R15
            switching_out   <= run_w;               // R15
            reference_out   <= ref_q;
            state_out       <= state_q;
            if (!run_w) begin
                stage_mode_out <= seq_pkg::STAGE_IDLE;
            end else if (sync_q.vin_gt_vout) begin
                stage_mode_out <= seq_pkg::STAGE_BUCK;  // R8
            end else if (sync_q.vin_lt_vout) begin
                stage_mode_out <= seq_pkg::STAGE_BOOST; // R8
            end else begin
                stage_mode_out <= seq_pkg::STAGE_ALT;   // R8
            end
            pfm_out <= run_w && sync_q.light_load && !mode_ctl_q[seq_pkg::FPWM_POS]; // R9
            high_side_off_out <= !run_w || sync_q.output_overvoltage_guard;      // R11
            discharge_out <= i2c_live_w && !oe_w && mode_ctl_q[seq_pkg::OUTPUT_DISCHARGE_BIT_POS]
                             && !sync_q.discharge_done;                        // R16
            // hysteresis: hold the choice between thresholds
            if (!sync_q.vin_gt_vout) begin
                if (sync_q.vin_above_bias_hi) begin
                    bias_from_vin_out <= 1'b1; // R12
                end else if (sync_q.vin_below_bias_lo) begin
                    bias_from_vin_out <= 1'b0; // R12
                end
            end else begin
                if (sync_q.vout_above_bias_hi) begin
                    bias_from_vin_out <= 1'b0; // R12
                end else if (sync_q.vout_below_bias_lo) begin
                    bias_from_vin_out <= 1'b1; // R12
                end
            end
            bias_external_out <= !sync_q.external_bias_select; // R13
        end
    end

endmodule // buck_boost_control_sequencer

// ==== tb/seq_ctl_model.sv ====
// behavioural i2c controller that hands acknowledged register writes to the sequencer
`timescale 1ns/1ns
module seq_ctl_model (
    // clock
    input  wire logic           clk_in,
    // acknowledged writes
    output seq_pkg::reg_write_t reg_write_out
);
    initial reg_write_out = '0;
    // idle fields are inverted so a stale value can never pass for a fresh write
    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
        @(negedge clk_in);
        reg_write_out <= '{1'b1, a, r, d};
        @(negedge clk_in);
        reg_write_out <= '{1'b0, ~a, ~r, ~d};
    endtask
endmodule // seq_ctl_model

// ==== tb/buck_boost_control_sequencer_chk.sv ====
// port assertions for the converter sequencer
`timescale 1ns/1ns
module buck_boost_control_sequencer_chk #(
    parameter int SOFT_START_CYCLES = 4096,
    parameter int HICCUP_CYCLES     = 100
) (
    input wire logic            clk_in,
    input wire logic            reset_in,
    input wire seq_pkg::sense_t sense_in,
    input wire logic [6:0]      target_addr_out,
    input wire logic            i2c_enable_out,
    input wire logic            switching_out,
    input wire logic [10:0]     reference_out,
    input wire logic [1:0]      stage_mode_out,
    input wire logic            high_side_off_out,
    input wire logic [3:0]      state_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // ****
    // sequences
    // ****
    // comparator inputs pass two flops, so a level must persist before it counts
    sequence s_ov_held;
        sense_in.output_overvoltage_guard [*4];
    endsequence
    sequence s_buck_held;
        (switching_out && sense_in.vin_gt_vout && !sense_in.vin_lt_vout) [*6];
    endsequence
    chk_addr_choice:
        assert property (target_addr_out == 7'h75 || target_addr_out == 7'h74)
        else $error("target address outside the strap choices");
    chk_off_quiet:
        assert property (state_out == 4'h1 |-> !i2c_enable_out && !switching_out)
        else $error("activity while off");
    chk_switch_active:
        assert property (switching_out |-> state_out == 4'h4)
        else $error("switching outside active state");
    chk_hiccup_quiet:
        assert property (state_out == 4'h8 |-> !switching_out)
        else $error("switching during hiccup");
    chk_ramp_start:
        assert property ($rose(switching_out) |-> reference_out <= 11'h1)
        else $error("ramp did not start from zero");
    chk_ramp_step:
        assert property (switching_out && $past(switching_out)
            |-> {1'b0, reference_out} <= {1'b0, $past(reference_out)} + 12'h1)
        else $error("reference jumped upward");
    chk_ov_off:
        assert property (s_ov_held |-> high_side_off_out)
        else $error("high sides on during overvoltage");
    chk_buck_map:
        assert property (s_buck_held |-> stage_mode_out == seq_pkg::STAGE_BUCK)
        else $error("not buck with vin above vout");
endmodule // buck_boost_control_sequencer_chk

bind buck_boost_control_sequencer buck_boost_control_sequencer_chk #(
    .SOFT_START_CYCLES(SOFT_START_CYCLES),
    .HICCUP_CYCLES    (HICCUP_CYCLES)
) chk (
    .clk_in(clk_in), .reset_in(reset_in), .sense_in(sense_in),
    .target_addr_out(target_addr_out), .i2c_enable_out(i2c_enable_out),
    .switching_out(switching_out), .reference_out(reference_out),
    .stage_mode_out(stage_mode_out), .high_side_off_out(high_side_off_out),
    .state_out(state_out)
);

// ==== tb/buck_boost_control_sequencer_bench.sv ====
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module buck_boost_control_sequencer_bench;
    localparam int         SS = 4096;
    localparam int         HC = 100;
    localparam logic [6:0] A  = seq_pkg::ADDR_STRAP_LOW;
    logic                clk_in   = 1'b0;
    logic                reset_in = 1'b1;
    seq_pkg::sense_t     sn       = '0;
    seq_pkg::reg_write_t rw;
    logic [6:0]          addr;
    logic                i2c, sw, pfm, hso, dis, bvin, bext;
    logic [10:0]         ref_v, tgt;
    logic [1:0]          stg;
    logic [3:0]          st;
    logic [31:0]         lf = 32'd73962;
    int                  err_total = 0;
    int                  checks    = 0;
    always #5 clk_in = ~clk_in;
    buck_boost_control_sequencer #(.SOFT_START_CYCLES(SS), .HICCUP_CYCLES(HC)) DUT (
        .clk_in(clk_in), .reset_in(reset_in), .sense_in(sn), .reg_write_in(rw),
        .target_addr_out(addr), .i2c_enable_out(i2c), .switching_out(sw),
        .reference_out(ref_v), .stage_mode_out(stg), .pfm_out(pfm),
        .high_side_off_out(hso), .discharge_out(dis), .bias_from_vin_out(bvin),
        .bias_external_out(bext), .state_out(st));
    seq_ctl_model host (.clk_in(clk_in), .reg_write_out(rw));
    // ****
    // helpers
    // ****
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [1:0] exp_stage(input logic gt, input logic lt);
        return gt ? seq_pkg::STAGE_BUCK : (lt ? seq_pkg::STAGE_BOOST : seq_pkg::STAGE_ALT);
    endfunction
    // lt: vin below vout, hi: the compared rail is above the upper threshold
    function automatic logic bias_vin(input logic lt, input logic hi);
        return lt ? hi : !hi;
    endfunction
    task automatic tk(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic finish_test;
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge clk_in);
        @(negedge clk_in) reset_in = 1'b0;
        sn.input_above_upper = 1'b1;
        sn.enable_standby = 1'b1;
        for (int s = 0; s < 2; s++) begin
            sn.addr_strap = s[0];
            sn.enable_shutdown = 1'b0;
            tk(8);
            `CHK(st, 4'h2)
            `CHK(addr, s[0] ? seq_pkg::ADDR_STRAP_HIGH : A)
            sn.enable_shutdown = 1'b1;
            tk(6);
            `CHK({st, addr}, {4'h1, 7'h75})
        end
        sn.addr_strap = 1'b0;
        sn.enable_shutdown = 1'b0;
        sn.enable_active = 1'b1;
        tk(10);
        sn.addr_strap = 1'b1;
        tk(6);
        `CHK({st, i2c, addr}, {4'h4, 1'b1, 7'h75})
        sn.input_undervoltage_lockout = 1'b1;
        sn.input_above_upper = 1'b0;
        tk(6);
        `CHK({st, i2c}, 5'h02)
        sn.input_undervoltage_lockout = 1'b0;
        sn.input_above_upper = 1'b1;
        // standby is entered afresh, so the strap is sampled again
        sn.addr_strap = 1'b0;
        tk(10);
        host.wr(7'h00, 8'h06, 8'h80);
        tk(4);
        `CHK({st, sw}, 5'h08)
        lf = lfsr_next(lfsr_next(lf));
        tgt = lf[10:0] | 11'h400;
        host.wr(A, 8'h00, tgt[7:0]);
        host.wr(A, 8'h01, {5'h00, tgt[10:8]});
        host.wr(A, 8'h06, 8'h80);
        tk(4);
        `CHK({sw, ref_v < tgt}, 2'b11)
        tk(SS + 20);
        `CHK(ref_v, tgt)
        for (int i = 0; i < 3; i++) begin
            sn.vin_gt_vout = (i == 0);
            sn.vin_lt_vout = (i == 1);
            tk(8);
            `CHK(stg, exp_stage(sn.vin_gt_vout, sn.vin_lt_vout))
        end
        for (int i = 0; i < 4; i++) begin
            sn.vin_lt_vout = i[1];
            sn.vin_gt_vout = !i[1];
            sn.vin_above_bias_hi = i[1] & i[0];
            sn.vin_below_bias_lo = i[1] & !i[0];
            sn.vout_above_bias_hi = !i[1] & i[0];
            sn.vout_below_bias_lo = !i[1] & !i[0];
            sn.external_bias_select = i[0];
            tk(8);
            `CHK(bvin, bias_vin(i[1], i[0]))
            `CHK(bext, !i[0])
        end
        sn.light_load = 1'b1;
        host.wr(A, 8'h06, 8'h82);
        tk(4);
        `CHK(pfm, 1'b0)
        host.wr(A, 8'h06, 8'h80);
        tk(4);
        `CHK(pfm, 1'b1)
        sn.output_overvoltage_guard = 1'b1;
        tk(6);
        `CHK(hso, 1'b1)
        sn.output_overvoltage_guard = 1'b0;
        tk(6);
        `CHK(hso, 1'b0)
        host.wr(A, 8'h06, 8'ha0);
        sn.output_short = 1'b1;
        tk(6);
        `CHK({st, sw}, 5'h10)
        sn.output_short = 1'b0;
        tk(HC + 10);
        `CHK({st, sw, ref_v < tgt}, 6'h13)
        host.wr(A, 8'h06, 8'h10);
        tk(4);
        `CHK({sw, dis, i2c}, 3'b011)
        sn.discharge_done = 1'b1;
        tk(6);
        `CHK(dis, 1'b0)
        sn.enable_shutdown = 1'b1;
        tk(6);
        sn.enable_shutdown = 1'b0;
        tk(12);
        host.wr(A, 8'h06, 8'h80);
        tk(20);
        `CHK({sw, ref_v}, 12'h800)
        finish_test();
    end
endmodule // buck_boost_control_sequencer_bench
